// ### src/ipp_prefetch_pipe.sv
`timescale 1ns/100ps
// Notes on behaviour
// - words awaiting decode sit in a pipe of three stages, one word each.
// - every word enters stage B and moves in order through C to D.
// - a word counts as fully decoded only once it sits in stage D.
// - each stage carries an abnormal-termination flag that moves with its word.
// - stage B is loaded only in answer to a sequencer prefetch request.
// - stages are sixteen bits wide and the holding register holds a full long word.
// - the holding register is filled from the cache or the bus in answer to a request.
// - an even-word fetch loads the whole long word and puts its upper half in stage B.
// - the next sequential word after a fault-free even fetch comes from the holding register alone.
// - the holding register serves words whether or not the cache is enabled.
// - each request goes to holding register, cache and bus controller in one cycle.
// - a holding-register hit aborts the bus cycle started for that request.
// - after a privilege change the pipe is emptied for refill from the new space.
module ipp_prefetch_pipe
  import ipp_pkg::*;
#(
  parameter int ADDR_W = IPP_ADDR_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // sequencer requests
  input wire logic req_valid_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [IPP_SPACE_W-1:0] req_space_i,
  output logic req_ready_o,
  // sequencer pipe control
  input wire logic consume_i,
  input wire logic flush_i,
  input wire logic priv_change_i,
  // cache and bus controller
  output logic fetch_req_o,
  output ipp_tag_t fetch_tag_o,
  output logic fetch_abort_o,
  input wire logic fill_valid_i,
  input wire logic [IPP_LONG_W-1:0] fill_data_i,
  input wire logic fill_fault_i,
  // decoded word and stage occupancy
  output ipp_stage_t dec_stage_o,
  output logic [IPP_STAGES-1:0] pipe_valid_o
);

  if (ADDR_W != IPP_ADDR_W) begin : g_addr_w_check
    $error("ipp_prefetch_pipe: ADDR_W must match the package tag width");
  end

  ipp_stage_t stage [IPP_STAGES];
  ipp_stage_t next_stage [IPP_STAGES];
  ipp_state_t st;
  ipp_state_t next_st;
  logic [IPP_LONG_W-1:0] hold_data;
  ipp_tag_t hold_tag;
  logic hold_valid;
  logic hold_fault;
  ipp_tag_t req_tag;
  logic req_odd;
  logic hit_q;
  logic discard;
  logic next_ready;

  // request decode
  wire logic flush_any = flush_i | priv_change_i;
  wire logic take = req_valid_i & req_ready_o & ~flush_any;
  wire ipp_tag_t in_tag = '{laddr: req_addr_i[ADDR_W-1:2], space: req_space_i};
  wire logic in_odd = req_addr_i[1];
  wire logic hit_now = hold_valid & (hold_tag == in_tag);

  // word sources
  wire logic hit_load = (st == IPP_ISSUE) & hit_q & ~flush_any;
  wire logic fill_load = (st == IPP_WAIT) & fill_valid_i & ~discard & ~flush_any;
  wire logic b_load = hit_load | fill_load;
  wire logic [IPP_WORD_W-1:0] hold_word = req_odd ? hold_data[IPP_LO_LSB +: IPP_WORD_W]
                                                  : hold_data[IPP_HI_LSB +: IPP_WORD_W];
  wire logic [IPP_WORD_W-1:0] fill_word = req_odd ? fill_data_i[IPP_LO_LSB +: IPP_WORD_W]
                                                  : fill_data_i[IPP_HI_LSB +: IPP_WORD_W];
  wire ipp_stage_t ins = hit_load ? '{valid: 1'b1, fault: hold_fault, word: hold_word}
                                  : '{valid: 1'b1, fault: fill_fault_i, word: fill_word};

  // stage advance, one step per cycle where the stage ahead is free
  wire logic d_free = ~stage[IPP_STG_D].valid | consume_i;
  wire logic c_free = ~stage[IPP_STG_C].valid | d_free;
  wire logic b_free = ~stage[IPP_STG_B].valid | c_free;

  always_comb begin
    next_stage[IPP_STG_D] = d_free ? stage[IPP_STG_C] : stage[IPP_STG_D];
    next_stage[IPP_STG_C] = c_free ? stage[IPP_STG_B] : stage[IPP_STG_C];
    if (b_free) begin
      next_stage[IPP_STG_B] = b_load ? ins : '0;
    end else begin
      next_stage[IPP_STG_B] = stage[IPP_STG_B];
    end
    if (flush_any) begin
      next_stage[IPP_STG_B] = '0;
      next_stage[IPP_STG_C] = '0;
      next_stage[IPP_STG_D] = '0;
    end
  end

  // fetch sequencing
  always_comb begin
    next_st = st;
    case (st)
      IPP_IDLE: begin
        if (take) begin
          next_st = IPP_ISSUE;
        end
      end
      IPP_ISSUE: begin
        if (hit_q) begin // holding hit needs no fill and goes straight back to idle
          next_st = IPP_IDLE;
        end else begin
          next_st = IPP_WAIT;
        end
      end
      IPP_WAIT: begin
        if (fill_valid_i) begin
          next_st = IPP_IDLE;
        end
      end
      default: begin
        next_st = IPP_IDLE;
      end
    endcase
  end

  // a request is accepted only while a stage is free after this cycle
  always_comb begin
    next_ready = (next_st == IPP_IDLE) &
                 ~(next_stage[IPP_STG_B].valid & next_stage[IPP_STG_C].valid & next_stage[IPP_STG_D].valid);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= IPP_IDLE;
      req_ready_o <= 1'b0;
      for (int i = 0; i < IPP_STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      st <= next_st;
      req_ready_o <= next_ready;
      for (int i = 0; i < IPP_STAGES; i++) begin
        stage[i] <= next_stage[i];
      end
    end
  end

  // request capture and issue to cache and bus together
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      req_tag <= '0;
      req_odd <= 1'b0;
      hit_q <= 1'b0;
      fetch_req_o <= 1'b0;
      fetch_abort_o <= 1'b0;
      fetch_tag_o <= '0;
    end else begin
      fetch_req_o <= take;
      fetch_abort_o <= take & hit_now;
      if (take) begin
        req_tag <= in_tag;
        req_odd <= in_odd;
        hit_q <= hit_now;
        fetch_tag_o <= in_tag;
      end
    end
  end

  // holding register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hold_valid <= 1'b0;
      hold_data <= IPP_LONG_RST;
      hold_tag <= '0;
      hold_fault <= 1'b0;
      discard <= 1'b0;
    end else begin
      if (flush_any) begin
        hold_valid <= 1'b0;
      end else if (fill_load) begin
        hold_valid <= ~fill_fault_i;
        hold_data <= fill_data_i;
        hold_tag <= req_tag;
        hold_fault <= fill_fault_i;
      end
      if (flush_any & ((st == IPP_WAIT & ~fill_valid_i) | (st == IPP_ISSUE & ~hit_q))) begin
        discard <= 1'b1;
      end else if (st == IPP_WAIT & fill_valid_i) begin
        discard <= 1'b0;
      end
    end
  end

  // decode stage and occupancy
  assign dec_stage_o = stage[IPP_STG_D];
  assign pipe_valid_o = {stage[IPP_STG_D].valid, stage[IPP_STG_C].valid, stage[IPP_STG_B].valid};

  // checks
  property p_no_overfill;
    @(posedge clk_sys_i) disable iff (srst_i)
    take |-> !(stage[IPP_STG_B].valid && stage[IPP_STG_C].valid && stage[IPP_STG_D].valid);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("request taken with pipe full");

  property p_b_to_c;
    @(posedge clk_sys_i) disable iff (srst_i)
    (stage[IPP_STG_B].valid && c_free && !flush_any) |=> (stage[IPP_STG_C] == $past(stage[IPP_STG_B]));
  endproperty
  a_b_to_c: assert property (p_b_to_c) else $error("stage B word did not move to C");

  property p_d_from_c;
    @(posedge clk_sys_i) disable iff (srst_i)
    $rose(dec_stage_o.valid) |-> $past(stage[IPP_STG_C].valid);
  endproperty
  a_d_from_c: assert property (p_d_from_c) else $error("stage D filled without passing C");

  property p_fault_travel;
    @(posedge clk_sys_i) disable iff (srst_i)
    (stage[IPP_STG_C].valid && d_free && !flush_any) |=> (dec_stage_o.fault == $past(stage[IPP_STG_C].fault));
  endproperty
  a_fault_travel: assert property (p_fault_travel) else $error("fault flag lost between C and D");

  property p_load_on_request;
    @(posedge clk_sys_i) disable iff (srst_i)
    (stage[IPP_STG_B].valid && !$past(stage[IPP_STG_B].valid)) |-> $past(st != IPP_IDLE, 1);
  endproperty
  a_load_on_request: assert property (p_load_on_request) else $error("stage B loaded without request");

  property p_even_upper;
    @(posedge clk_sys_i) disable iff (srst_i)
    (fill_load && !req_odd && b_free) |=> (stage[IPP_STG_B].word == $past(fill_data_i[IPP_HI_LSB +: IPP_WORD_W]));
  endproperty
  a_even_upper: assert property (p_even_upper) else $error("even fetch did not load upper word");

  property p_hit_no_wait;
    @(posedge clk_sys_i) disable iff (srst_i)
    (take && hit_now) |=> (fetch_abort_o && fetch_req_o) ##1 (st == IPP_IDLE);
  endproperty
  a_hit_no_wait: assert property (p_hit_no_wait) else $error("holding hit did not abort and finish");

  property p_issue_together;
    @(posedge clk_sys_i) disable iff (srst_i)
    take |=> (fetch_req_o && fetch_tag_o == $past(in_tag));
  endproperty
  a_issue_together: assert property (p_issue_together) else $error("request not issued next cycle");

  property p_flush_empty;
    @(posedge clk_sys_i) disable iff (srst_i)
    flush_any |=> (pipe_valid_o == 3'h0 && !hold_valid);
  endproperty
  a_flush_empty: assert property (p_flush_empty) else $error("flush left pipe or holding valid");

  property p_hit_tag;
    @(posedge clk_sys_i) disable iff (srst_i)
    fetch_abort_o |-> ($past(hold_valid) && ($past(hold_tag) == fetch_tag_o));
  endproperty
  a_hit_tag: assert property (p_hit_tag) else $error("hit without matching tag");

  property p_miss_no_abort;
    @(posedge clk_sys_i) disable iff (srst_i)
    (fetch_req_o && !fetch_abort_o) |-> !($past(hold_valid) && ($past(hold_tag) == fetch_tag_o));
  endproperty
  a_miss_no_abort: assert property (p_miss_no_abort) else $error("matching tag went to cache or bus");

  property p_one_outstanding;
    @(posedge clk_sys_i) disable iff (srst_i)
    discard |-> (st == IPP_WAIT && !req_ready_o);
  endproperty
  a_one_outstanding: assert property (p_one_outstanding) else $error("request open while fill pending");

  property p_ready_full;
    @(posedge clk_sys_i) disable iff (srst_i)
    (pipe_valid_o == 3'h7) |-> !req_ready_o;
  endproperty
  a_ready_full: assert property (p_ready_full) else $error("ready shown with pipe full");

  property p_odd_lower;
    @(posedge clk_sys_i) disable iff (srst_i)
    (fill_load && req_odd && b_free) |=> (stage[IPP_STG_B].word == $past(fill_data_i[IPP_LO_LSB +: IPP_WORD_W]));
  endproperty
  a_odd_lower: assert property (p_odd_lower) else $error("odd fetch did not load lower word");

  property p_hit_clean;
    @(posedge clk_sys_i) disable iff (srst_i)
    hit_load |=> (stage[IPP_STG_B].valid && !stage[IPP_STG_B].fault);
  endproperty
  a_hit_clean: assert property (p_hit_clean) else $error("holding hit did not load a clean word");

  property p_d_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
    (dec_stage_o.valid && !consume_i && !flush_any) |=> (dec_stage_o == $past(dec_stage_o));
  endproperty
  a_d_hold: assert property (p_d_hold) else $error("decoded word left stage D unconsumed");

  c_hit: cover property (@(posedge clk_sys_i) disable iff (srst_i) take && hit_now);
  c_miss_fill: cover property (@(posedge clk_sys_i) disable iff (srst_i) fill_load && !req_odd);
  c_fault_at_d: cover property (@(posedge clk_sys_i) disable iff (srst_i) dec_stage_o.valid && dec_stage_o.fault);
  c_full: cover property (@(posedge clk_sys_i) disable iff (srst_i) pipe_valid_o == 3'h7);
  c_discard: cover property (@(posedge clk_sys_i) disable iff (srst_i) discard && fill_valid_i);

endmodule

// ### src/ipp_pkg.sv
package ipp_pkg;

  // pipe geometry
  localparam int IPP_STAGES = 3;
  localparam int IPP_WORD_W = 16;
  localparam int IPP_LONG_W = 32;
  localparam int IPP_SPACE_W = 3;
  localparam int IPP_ADDR_W = 32;

  // stage indices
  localparam int IPP_STG_B = 0;
  localparam int IPP_STG_C = 1;
  localparam int IPP_STG_D = 2;

  // word position inside the long word
  localparam int IPP_HI_LSB = 16;
  localparam int IPP_LO_LSB = 0;

  // reset values
  localparam logic [IPP_WORD_W-1:0] IPP_WORD_RST = 16'h0000;
  localparam logic [IPP_LONG_W-1:0] IPP_LONG_RST = 32'h0000_0000;
  localparam logic [IPP_SPACE_W-1:0] IPP_SPACE_RST = 3'h0;

  // fetch timing: request leaves one cycle after it is taken
  localparam int IPP_ISSUE_LAT = 1;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [IPP_WORD_W-1:0] word;
  } ipp_stage_t;

  typedef struct packed {
    logic [IPP_ADDR_W-1:2] laddr;
    logic [IPP_SPACE_W-1:0] space;
  } ipp_tag_t;

  typedef enum logic [1:0] {
    IPP_IDLE  = 2'b00,
    IPP_ISSUE = 2'b01,
    IPP_WAIT  = 2'b10
  } ipp_state_t;

endpackage

// ### verif/ipp_mem_model.sv
`timescale 1ns/100ps
// cache and bus controller on the far side of the prefetch pipe
module ipp_mem_model
  import ipp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // requests from the pipe
  input wire logic fetch_req_i,
  input wire ipp_tag_t fetch_tag_i,
  input wire logic fetch_abort_i,
  // bench control
  input wire logic fault_i,
  input wire logic slow_i,
  // answers
  output logic fill_valid_o = 1'b0,
  output logic [IPP_LONG_W-1:0] fill_data_o = 32'h5A5A_C3C3,
  output logic fill_fault_o = 1'b0
);
  ipp_tag_t tag;
  logic busy = 1'b0;
  // fault is fixed when the request is taken
  logic flt = 1'b0;
  int cnt = 0;
  // data outside a fill is junk that changes every cycle
  always @(posedge clk_sys_i) begin
    fill_valid_o <= 1'b0;
    fill_data_o <= ~fill_data_o;
    fill_fault_o <= ~fill_fault_o;
    if (srst_i) begin
      busy <= 1'b0;
    end else if (fetch_req_i && !fetch_abort_i) begin
      busy <= 1'b1;
      tag <= fetch_tag_i;
      flt <= fault_i;
      cnt <= slow_i ? 5 : 0;
    end else if (busy && cnt == 0) begin
      fill_valid_o <= 1'b1;
      fill_data_o <= {tag.laddr[17:2], tag.laddr[14:2], tag.space};
      fill_fault_o <= flt;
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ### verif/ipp_prefetch_pipe_tb_top.sv
`timescale 1ns/100ps
module ipp_prefetch_pipe_tb_top
  import ipp_pkg::*;
;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, req_valid_i = 1'b0, consume_i = 1'b0;
  logic flush_i = 1'b0, priv_change_i = 1'b0, fault_en = 1'b0, slow = 1'b0;
  logic [31:0] req_addr_i = 32'h0, a, fill_data_i;
  logic [2:0] req_space_i = 3'h0, s, pipe_valid_o;
  logic req_ready_o, fetch_req_o, fetch_abort_o, fill_valid_i, fill_fault_i, hv;
  ipp_tag_t fetch_tag_o, ht;
  ipp_stage_t dec_stage_o;
  logic [16:0] q[$];
  int fails = 0, num_checks = 0, n;
  always #2 clk_sys_i = ~clk_sys_i;
  ipp_prefetch_pipe DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
    .req_addr_i(req_addr_i), .req_space_i(req_space_i), .req_ready_o(req_ready_o), .consume_i(consume_i),
    .flush_i(flush_i), .priv_change_i(priv_change_i), .fetch_req_o(fetch_req_o), .fetch_tag_o(fetch_tag_o),
    .fetch_abort_o(fetch_abort_o), .fill_valid_i(fill_valid_i), .fill_data_i(fill_data_i),
    .fill_fault_i(fill_fault_i), .dec_stage_o(dec_stage_o), .pipe_valid_o(pipe_valid_o));
  ipp_mem_model mem (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .fetch_req_i(fetch_req_o),
    .fetch_tag_i(fetch_tag_o), .fetch_abort_i(fetch_abort_o), .fault_i(fault_en), .slow_i(slow),
    .fill_valid_o(fill_valid_i), .fill_data_o(fill_data_i), .fill_fault_o(fill_fault_i));
  task automatic chk(logic [35:0] got, logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // sequencer request: held until the pipe shows it was taken
  task automatic fetch(logic [31:0] ad, logic [2:0] sp, logic f);
    ipp_tag_t t;
    logic hit;
    logic [31:0] d;
    int k;
    t = {ad[31:2], sp};
    hit = hv && (ht === t);
    d = {t.laddr[17:2], t.laddr[14:2], t.space};
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_addr_i <= ad;
    req_space_i <= sp;
    fault_en <= f;
    slow <= 1'($urandom);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end while (fetch_req_o !== 1'b1 && k < 50);
    chk(36'(fetch_tag_o), 36'(t));
    chk(36'(fetch_abort_o), 36'(hit));
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    if (!hit) begin
      hv = !f;
      ht = t;
    end
    q.push_back({hit ? 1'b0 : f, ad[1] ? d[15:0] : d[31:16]});
  endtask
  task automatic drain();
    logic [16:0] e;
    int k;
    while (q.size() > 0) begin
      #1;
      e = q.pop_front();
      k = 0;
      while (dec_stage_o.valid !== 1'b1 && k < 50) begin
        @(posedge clk_sys_i);
        #1;
        k++;
      end
      chk(36'({dec_stage_o.fault, dec_stage_o.word}), 36'(e));
      @(posedge clk_sys_i);
      consume_i <= 1'b1;
      @(posedge clk_sys_i);
      consume_i <= 1'b0;
    end
  endtask
  task automatic flush_pipe(logic p);
    @(posedge clk_sys_i);
    if (p) priv_change_i <= 1'b1;
    else flush_i <= 1'b1;
    @(posedge clk_sys_i);
    flush_i <= 1'b0;
    priv_change_i <= 1'b0;
    #1;
    chk(36'(pipe_valid_o), 36'h0);
    hv = 1'b0;
    q.delete();
  endtask
  // miss cut by a flush while it is issued; its late fill must be dropped
  task automatic cut_fetch(logic [31:0] ad, logic [2:0] sp);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_addr_i <= ad;
    req_space_i <= sp;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    flush_i <= 1'b1;
    #1;
    chk(36'({fetch_req_o, fetch_abort_o}), 36'h2);
    @(posedge clk_sys_i);
    flush_i <= 1'b0;
    #1;
    chk(36'({pipe_valid_o, req_ready_o}), 36'h0);
    hv = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hF9AB));
    hv = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk(36'(pipe_valid_o), 36'h0);
    for (int i = 0; i < 20; i++) begin
      a = $urandom & 32'hFFFF_FFFC;
      s = 3'($urandom);
      fetch(a, s, 1'b0);
      fetch(a | 32'h2, (i % 3 == 0) ? s ^ 3'h1 : s, 1'b0);
      fetch($urandom, 3'($urandom), i[0] ? 1'b0 : 1'($urandom));
      #1;
      n = 0;
      while (pipe_valid_o !== 3'b111 && n < 50) begin
        @(posedge clk_sys_i);
        #1;
        n++;
      end
      chk(36'(pipe_valid_o), 36'h7);
      chk(36'(req_ready_o), 36'h0);
      if (i[0]) begin
        flush_pipe(i[1]);
        cut_fetch(a, s);
      end else begin
        drain();
        flush_pipe(1'b0);
      end
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
